// File: hw/pmt_pkg.sv
package pmt_pkg;
  // ==========================================================
  // Register byte addresses (APB, one word each)
  localparam logic [7:0] ADDR_SETUP     = 8'h00; // Control register
  localparam logic [7:0] ADDR_COUNT     = 8'h04; // Timer count value
  localparam logic [7:0] ADDR_PERIOD    = 8'h08; // Period limit
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0C; // Sticky flags, write one to clear
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h10; // Enable mask, same layout
  // ==========================================================
  // Field positions
  localparam int SETUP_PS_LSB   = 0; // Prescale select, two bits
  localparam int SETUP_RUN_BIT  = 2; // Run bit
  localparam int SETUP_POST_LSB = 3; // Postscale select, four bits
  localparam int IRQ_MATCH_BIT  = 1; // Match flag position
  localparam logic [7:0] SETUP_WMASK = 8'h7F; // Top bit unimplemented
  // ==========================================================
  // Reset values
  localparam logic [7:0] SETUP_RST  = 8'h00;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [7:0] FLAGS_RST   = 8'h00; // No event pending
  localparam logic [7:0] ENABLES_RST = 8'h00; // Everything masked
  // ==========================================================
  // Prescale thresholds (terminal count of the 4-bit prescaler)
  localparam logic [3:0] PS_TC_DIV1  = 4'h0;
  localparam logic [3:0] PS_TC_DIV4  = 4'h3;
  localparam logic [3:0] PS_TC_DIV16 = 4'hF;
  // Instruction clock is bus clock divided by four
  localparam logic [1:0] INSTR_DIV_TC = 2'h3;

  // Outputs toward neighbour modules
  typedef struct packed {
    logic match;     // Unscaled match pulse, PWM time base
    logic shift_clk; // Shift clock offer to serial port
  } timer_out_s;
endpackage

// File: hw/period_match_timer_8bit.sv
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ns
// How it works
// - Count increments from zero on prescaled instruction ticks
// - Four-bit prescaler divides by one, four, sixteen
// - Compare count with period every cycle, match
// - Match zeroes count, advances postscaler
// - Count and period readable and writable anytime
// - Reset clears count, period loads all ones
// - Count/control writes and reset clear scalers
// - Control write leaves count unchanged
// - Run bit starts; cleared stops everything
// - Postscaler reaching selection sets latched flag
// - Interrupt requested only when enable set
// - Flag sets regardless of enable, pollable
// - Match offered as serial shift clock
// - Unscaled match feeds PWM units
module period_match_timer_8bit (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Neighbour outputs and interrupt
  output pmt_pkg::timer_out_s    tout,
  output logic                   irq
);
  // ==========================================================
  // Registers and internal state
  logic [7:0] timer_setup;        // Control register, bit 7 always zero
  logic [7:0] timer_count_value;  // Running count
  logic [7:0] period_limit;       // Match value
  logic [7:0] periph_irq_flags;   // Sticky status
  logic [7:0] periph_irq_enables; // Mask
  logic [1:0] instr_div;          // Bus clock to instruction clock divider
  logic [3:0] pre_cnt;            // Prescale counter
  logic [3:0] post_cnt;           // Postscale counter
  logic [3:0] pre_tc;             // Selected prescale terminal count
  logic       instr_tick;         // Instruction clock enable
  logic       tick;               // Prescaled count enable
  logic       run;                // Run bit
  logic       equal;              // Count equals period
  logic       match;              // Match event on a counting tick
  logic       post_hit;           // Postscaler reached selection
  logic       wr_en;              // APB write strobe
  logic       wr_setup;
  logic       wr_count;
  logic       wr_period;
  logic       wr_flags;
  logic       wr_en_reg;
  logic       addr_ok;            // Mapped address
  logic [31:0] read_word;         // Register selected by the address
  logic [1:0] ps_sel;             // Prescale select field
  logic [3:0] post_sel;           // Postscale select field

  // ==========================================================
  // APB decode; zero wait states
  assign pready  = 1'b1;
  assign addr_ok = (paddr == pmt_pkg::ADDR_SETUP) || (paddr == pmt_pkg::ADDR_COUNT) ||
                   (paddr == pmt_pkg::ADDR_PERIOD) || (paddr == pmt_pkg::ADDR_IRQ_FLAGS) ||
                   (paddr == pmt_pkg::ADDR_IRQ_EN);
  assign pslverr   = psel && penable && !addr_ok;
  assign wr_en     = psel && penable && pwrite;
  assign wr_setup  = wr_en && (paddr == pmt_pkg::ADDR_SETUP);
  assign wr_count  = wr_en && (paddr == pmt_pkg::ADDR_COUNT);
  assign wr_period = wr_en && (paddr == pmt_pkg::ADDR_PERIOD);
  assign wr_flags  = wr_en && (paddr == pmt_pkg::ADDR_IRQ_FLAGS);
  assign wr_en_reg = wr_en && (paddr == pmt_pkg::ADDR_IRQ_EN);

  // Read mux feeding the read data register
  always_comb begin
    read_word = 32'h0000_0000;
    unique case (paddr)
      pmt_pkg::ADDR_SETUP:     read_word[7:0] = timer_setup;
      pmt_pkg::ADDR_COUNT:     read_word[7:0] = timer_count_value;
      pmt_pkg::ADDR_PERIOD:    read_word[7:0] = period_limit;
      pmt_pkg::ADDR_IRQ_FLAGS: read_word[7:0] = periph_irq_flags;
      pmt_pkg::ADDR_IRQ_EN:    read_word[7:0] = periph_irq_enables;
      default:                 read_word      = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup phase and stands through the access
  // phase; a running count is thus read one cycle early, which software
  // cannot tell apart from bus latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= read_word;
    end
  end

  // ==========================================================
  // Control register; top bit masked off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_setup <= pmt_pkg::SETUP_RST;
    end else if (wr_setup) begin
      timer_setup <= pwdata[7:0] & pmt_pkg::SETUP_WMASK;
    end
  end

  assign run      = timer_setup[pmt_pkg::SETUP_RUN_BIT];
  assign ps_sel   = timer_setup[pmt_pkg::SETUP_PS_LSB +: 2];
  assign post_sel = timer_setup[pmt_pkg::SETUP_POST_LSB +: 4];

  // Period register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_limit <= pmt_pkg::PERIOD_RST;
    end else if (wr_period) begin
      period_limit <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Instruction clock enable: every fourth bus clock, only while running
  // Gating the divider too keeps the block quiet when stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_div <= 2'h0;
    end else if (!run) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end

  assign instr_tick = run && (instr_div == pmt_pkg::INSTR_DIV_TC);

  // Prescale selection
  always_comb begin
    unique case (ps_sel)
      2'b00:   pre_tc = pmt_pkg::PS_TC_DIV1;
      2'b01:   pre_tc = pmt_pkg::PS_TC_DIV4;
      default: pre_tc = pmt_pkg::PS_TC_DIV16;
    endcase
  end

  // A write that restarts the scalers also swallows a tick due in the same
  // cycle, so a control write can never move the count
  assign tick = instr_tick && (pre_cnt >= pre_tc) && !wr_setup && !wr_count;

  // Prescale counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 4'h0;
    end else if (wr_count || wr_setup) begin
      pre_cnt <= 4'h0;
    end else if (tick) begin
      pre_cnt <= 4'h0;
    end else if (instr_tick) begin
      pre_cnt <= pre_cnt + 4'h1;
    end
  end

  // ==========================================================
  // Comparator and match; a match is qualified by a counting tick so
  // it lasts one bus cycle and the count restarts on that tick
  assign equal = (timer_count_value == period_limit);
  assign match = tick && equal;

  // Count register; a control write does not touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_value <= pmt_pkg::COUNT_RST;
    end else if (wr_count) begin
      timer_count_value <= pwdata[7:0];
    end else if (match) begin
      timer_count_value <= 8'h00;
    end else if (tick) begin
      timer_count_value <= timer_count_value + 8'h01;
    end
  end

  // ==========================================================
  // Postscaler: counts matches, hits at the selected number plus one
  assign post_hit = match && (post_cnt >= post_sel);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_cnt <= 4'h0;
    end else if (wr_count || wr_setup) begin
      post_cnt <= 4'h0;
    end else if (post_hit) begin
      post_cnt <= 4'h0;
    end else if (match) begin
      post_cnt <= post_cnt + 4'h1;
    end
  end

  // ==========================================================
  // Sticky flag; set beats a simultaneous clear, hardware never clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq_flags <= pmt_pkg::FLAGS_RST;
    end else begin
      if (wr_flags) begin
        periph_irq_flags[pmt_pkg::IRQ_MATCH_BIT] <=
          periph_irq_flags[pmt_pkg::IRQ_MATCH_BIT] & ~pwdata[pmt_pkg::IRQ_MATCH_BIT];
      end
      if (post_hit) begin
        periph_irq_flags[pmt_pkg::IRQ_MATCH_BIT] <= 1'b1;
      end
    end
  end

  // Enable mask; only the match bit exists
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_irq_enables <= pmt_pkg::ENABLES_RST;
    end else if (wr_en_reg) begin
      periph_irq_enables[pmt_pkg::IRQ_MATCH_BIT] <= pwdata[pmt_pkg::IRQ_MATCH_BIT];
    end
  end

  // Level interrupt
  assign irq = |(periph_irq_flags & periph_irq_enables);

  // ==========================================================
  // Neighbour outputs, registered one cycle after the match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout <= '0;
    end else begin
      tout.match     <= match;
      tout.shift_clk <= match;
    end
  end

  // ==========================================================
  // Assertions
  // All but a_read_count watch design state only; the bench covers the rest of the bus side.
  // All are cut off while reset is low, so nothing fires on its release.

  // A counting tick that hits the period and is not overridden by a write
  sequence s_match_seen;
    match && !wr_count;
  endsequence

  // Three bus cycles without an instruction tick
  sequence s_instr_quiet;
    !instr_tick [*3];
  endsequence

  // Restart seen on the outputs, then the pulse is gone again
  sequence s_pulse_after;
    tout.match && timer_count_value == 8'h00 ##1 !tout.match;
  endsequence

  // Counting
  a_match_zeroes_count: assert property (@(posedge pclk) disable iff (!presetn)
    s_match_seen |=> timer_count_value == 8'h00)
    else $error("count not zero after match");

  a_tick_increments: assert property (@(posedge pclk) disable iff (!presetn)
    tick && !equal && !wr_count |=> timer_count_value == $past(timer_count_value) + 8'h01)
    else $error("count did not increment");

  a_instr_rate: assert property (@(posedge pclk) disable iff (!presetn)
    instr_tick |=> s_instr_quiet)
    else $error("instruction tick faster than one in four");

  a_stopped_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    !run && !wr_count |=> $stable(timer_count_value))
    else $error("count moved while stopped");

  a_setup_keeps_count: assert property (@(posedge pclk) disable iff (!presetn)
    wr_setup |=> $stable(timer_count_value))
    else $error("control write changed count");

  // Prescaler and postscaler
  a_scalers_cleared: assert property (@(posedge pclk) disable iff (!presetn)
    wr_setup || wr_count |=> pre_cnt == 4'h0 && post_cnt == 4'h0)
    else $error("scalers not cleared");

  a_div1_every_instr: assert property (@(posedge pclk) disable iff (!presetn)
    instr_tick && ps_sel == 2'b00 && !wr_setup && !wr_count |-> tick)
    else $error("div1 missed tick");

  a_div4_only_fourth: assert property (@(posedge pclk) disable iff (!presetn)
    instr_tick && ps_sel == 2'b01 && pre_cnt != pmt_pkg::PS_TC_DIV4 |-> !tick)
    else $error("div4 ticked early");

  a_div16_only_last: assert property (@(posedge pclk) disable iff (!presetn)
    instr_tick && ps_sel[1] && pre_cnt != pmt_pkg::PS_TC_DIV16 |-> !tick)
    else $error("div16 ticked early");

  a_prescale_bound: assert property (@(posedge pclk) disable iff (!presetn)
    pre_cnt <= pre_tc && (!tick || instr_tick))
    else $error("prescaler out of range or tick without instruction clock");

  a_post_bound: assert property (@(posedge pclk) disable iff (!presetn)
    post_cnt <= post_sel)
    else $error("postscaler passed its selection");

  // Match outputs
  a_match_output: assert property (@(posedge pclk) disable iff (!presetn)
    match |=> tout.match && tout.shift_clk)
    else $error("match output missing");

  a_pulse_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    s_match_seen |=> s_pulse_after)
    else $error("match pulse not a single restart cycle");

  // Flag, mask and interrupt
  a_flag_on_hit: assert property (@(posedge pclk) disable iff (!presetn)
    post_hit |=> periph_irq_flags[pmt_pkg::IRQ_MATCH_BIT])
    else $error("flag not set");

  a_flag_needs_hit: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(periph_irq_flags[pmt_pkg::IRQ_MATCH_BIT]) |-> $past(post_hit))
    else $error("flag set without postscaler hit");

  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    periph_irq_flags[pmt_pkg::IRQ_MATCH_BIT] && !wr_flags |=>
    periph_irq_flags[pmt_pkg::IRQ_MATCH_BIT])
    else $error("flag lost");

  a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
    post_hit && periph_irq_enables[pmt_pkg::IRQ_MATCH_BIT] && !wr_en_reg |=> irq)
    else $error("enabled event raised no interrupt");

  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    !periph_irq_enables[pmt_pkg::IRQ_MATCH_BIT] |-> !irq)
    else $error("interrupt while masked");

  // Register file
  a_top_bit_zero: assert property (@(posedge pclk) disable iff (!presetn)
    timer_setup[7] == 1'b0)
    else $error("control top bit set");

  a_read_count: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr == pmt_pkg::ADDR_COUNT |=>
    prdata == {24'h000000, $past(timer_count_value)})
    else $error("count read data wrong");
endmodule

// File: sim/pwm_timebase_model.sv
`timescale 1ns/1ns
// ==========================================================
// Neighbour model: PWM unit and serial port using the match pulse
module pwm_timebase_model (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Timer outputs
  input  wire pmt_pkg::timer_out_s tout,
  // Observations for the bench
  output logic      [15:0]         pulses,   // Time base pulses seen
  output logic                     diverged  // Sticky, shift clock strayed
);
  // Count pulses as a PWM period counter would; a level would count many
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulses   <= 16'h0000;
      diverged <= 1'b0;
    end else begin
      if (tout.match) pulses <= pulses + 16'h0001;
      // Serial port takes the same pulse as its shift clock
      if (tout.shift_clk !== tout.match) diverged <= 1'b1;
    end
  end
endmodule

// File: sim/tb_period_match_timer_8bit.sv
`timescale 1ns/1ns
// ==========================================================
// Bench top
module tb_period_match_timer_8bit;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]          paddr, v;
  logic [31:0]         pwdata, prdata;
  logic [15:0]         pulses;
  logic                diverged;
  pmt_pkg::timer_out_s tout;
  logic [8:0]          expq[$];  // Expected {pslverr, data} of each read
  int                  bad_count, compares, r, n, p, dv;

  period_match_timer_8bit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tout(tout), .irq(irq));
  pwm_timebase_model nbr (.pclk(pclk), .presetn(presetn), .tout(tout),
    .pulses(pulses), .diverged(diverged));

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watcher: takes the oldest note whenever read data is sampled
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expq.size() == 0) check(16'hFFFF, 16'h0000);
      else check({7'h00, pslverr, prdata[7:0]}, {7'h00, expq.pop_front()});
    end
  end

  // ==========================================================
  // APB master; never assumes the wait length, bounded anyway
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      bad_count++;
      conclude();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic err);
    expq.push_back({err, e});
    apb(a, 1'b0, 8'h00);
  endtask
  // Cycles until the neighbour sees the next match pulse
  task automatic wait_match(output int c);
    logic [15:0] start;
    start = pulses;
    c = 0;
    while (pulses === start && c < 3000) begin
      @(posedge pclk);
      c++;
    end
    if (c >= 3000) begin
      bad_count++;
      conclude();
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h00000000; bad_count = 0; compares = 0;
    r = $urandom(6);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(pmt_pkg::ADDR_SETUP, 8'h00, 1'b0);
    rd(pmt_pkg::ADDR_COUNT, 8'h00, 1'b0);
    rd(pmt_pkg::ADDR_PERIOD, 8'hFF, 1'b0);
    rd(8'h14, 8'h00, 1'b1);
    wr(pmt_pkg::ADDR_SETUP, 8'hFF);
    rd(pmt_pkg::ADDR_SETUP, 8'h7F, 1'b0);
    $display("reset and setup test done");
    // Stopped timer keeps a written count across a control write
    wr(pmt_pkg::ADDR_SETUP, 8'h00);
    v = 8'($urandom_range(255));
    wr(pmt_pkg::ADDR_COUNT, v);
    wr(pmt_pkg::ADDR_SETUP, 8'h03);
    repeat (100) @(posedge pclk);
    rd(pmt_pkg::ADDR_COUNT, v, 1'b0);
    v = 8'($urandom_range(255));
    wr(pmt_pkg::ADDR_PERIOD, v);
    rd(pmt_pkg::ADDR_PERIOD, v, 1'b0);
    $display("stopped access test done");
    // Match spacing for every prescale code and a random period
    for (int c = 0; c < 4; c++) begin
      p = $urandom_range(5, 1);
      dv = (c == 0) ? 1 : (c == 1) ? 4 : 16;
      wr(pmt_pkg::ADDR_PERIOD, 8'(p));
      wr(pmt_pkg::ADDR_COUNT, 8'h00);
      wr(pmt_pkg::ADDR_SETUP, 8'(c) | 8'h04);
      wait_match(n);
      wait_match(n);
      check(16'(n), 16'((p + 1) * 4 * dv));
    end
    $display("prescale test done");
    // Every postscale code: flag after exactly sel+1 matches, masked
    wr(pmt_pkg::ADDR_PERIOD, 8'h02);
    for (int s = 0; s < 16; s++) begin
      wr(pmt_pkg::ADDR_SETUP, 8'h00);
      wr(pmt_pkg::ADDR_COUNT, 8'h00);
      wr(pmt_pkg::ADDR_IRQ_FLAGS, 8'h02);
      wr(pmt_pkg::ADDR_SETUP, 8'(s << 3) | 8'h04);
      repeat (s) wait_match(n);
      rd(pmt_pkg::ADDR_IRQ_FLAGS, 8'h00, 1'b0);
      wait_match(n);
      rd(pmt_pkg::ADDR_IRQ_FLAGS, 8'h02, 1'b0);
      check({15'h0000, irq}, 16'h0000);
    end
    wr(pmt_pkg::ADDR_IRQ_EN, 8'h02);
    @(posedge pclk);
    check({15'h0000, irq}, 16'h0001);
    wr(pmt_pkg::ADDR_SETUP, 8'h00);
    wr(pmt_pkg::ADDR_IRQ_FLAGS, 8'h02);
    @(posedge pclk);
    check({15'h0000, irq}, 16'h0000);
    $display("postscale and interrupt test done");
    // Reset in mid-run restores the documented values
    wr(pmt_pkg::ADDR_PERIOD, 8'h11);
    wr(pmt_pkg::ADDR_SETUP, 8'h04);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(pmt_pkg::ADDR_PERIOD, 8'hFF, 1'b0);
    rd(pmt_pkg::ADDR_COUNT, 8'h00, 1'b0);
    check({15'h0000, diverged}, 16'h0000);
    $display("mid-run reset test done");
    conclude();
  end
endmodule
